// >>> common/dao_pkg.sv
// Shared constants, state type and decode helpers of the dual converter output stage
package dao_pkg;

	// ********************************************************************
	// Sizes and counts
	// ********************************************************************
	localparam int DAO_WIDTH   = 12;     // Result bits per channel, top bit is the MSB
	localparam int DAO_LATENCY = 5;      // Sample clock edges from sample to output word

	// ********************************************************************
	// Values after reset
	// ********************************************************************
	localparam logic DAO_RST_BIT  = 1'b0;
	localparam logic DAO_RST_OE_N = 1'b1; // Buses released until the pins are seen

	// ********************************************************************
	// Format pin levels, quantised by the front end
	// ********************************************************************
	localparam logic [1:0] DAO_LVL_GND        = 2'h0;
	localparam logic [1:0] DAO_LVL_THIRD      = 2'h1;
	localparam logic [1:0] DAO_LVL_TWO_THIRDS = 2'h2;
	localparam logic [1:0] DAO_LVL_SUPPLY     = 2'h3;

	// Channel power and drive modes
	typedef enum logic [1:0] {DAO_ST_NORMAL, DAO_ST_HIZ, DAO_ST_NAP, DAO_ST_SLEEP} dao_chan_state_e;

	// Two's complement at the two upper levels
	function automatic logic dao_twos_sel(input logic [1:0] lvl);
		return (lvl == DAO_LVL_TWO_THIRDS) || (lvl == DAO_LVL_SUPPLY);
	endfunction : dao_twos_sel

	// Duty stabilizer only at the two middle levels
	function automatic logic dao_dcs_sel(input logic [1:0] lvl);
		return (lvl == DAO_LVL_THIRD) || (lvl == DAO_LVL_TWO_THIRDS);
	endfunction : dao_dcs_sel

	// Mode from power-down and active-low enable
	function automatic dao_chan_state_e dao_chan_state(input logic pd, input logic oe_n);
		if (!pd && !oe_n)
			return DAO_ST_NORMAL;
		else if (!pd)
			return DAO_ST_HIZ;
		else if (!oe_n)
			return DAO_ST_NAP;
		else
			return DAO_ST_SLEEP;
	endfunction : dao_chan_state

endpackage : dao_pkg

// >>> common/dao_chan_if.sv
// Carrier from one channel sampler to the output stage
`timescale 1ns/1ns
`default_nettype none
interface dao_chan_if
	import dao_pkg::*;
#(
	parameter int W = DAO_WIDTH
);
	logic [W-1:0]    word;       // Formatted result
	logic            ovr;        // Over or under range of that result
	logic            drive;      // Channel wants its bus driven
	dao_chan_state_e state;      // Current mode
	logic            edge_seen;  // Pulse: a sample clock rise was taken
	logic            clk_level;  // Synchronised sample clock level

	modport chan (output word, ovr, drive, state, edge_seen, clk_level);
	modport top  (input  word, ovr, drive, state, edge_seen, clk_level);
endinterface : dao_chan_if
`default_nettype wire

// >>> design/dao_channel.sv
// Per-channel sampler: pin synchronisers, sample pipeline, mode decode, output format
`timescale 1ns/1ns
`default_nettype none
module dao_channel
	import dao_pkg::*;
#(
	parameter int W   = DAO_WIDTH,
	parameter int LAT = DAO_LATENCY
)
(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Channel pins, asynchronous to clk
	input  wire logic         sample_clock,
	input  wire logic [W-1:0] sample_in,
	input  wire logic         over_in,
	input  wire logic         power_down,
	input  wire logic         output_enable_n,
	// Shared format, already on clk
	input  wire logic         twos_comp,
	// Results toward the output stage
	dao_chan_if.chan          ch
);

	logic         clk_s1, clk_s2, clk_s3;
	logic [W-1:0] data_s1, data_s2;
	logic         ovr_s1, ovr_s2;
	logic         pd_s1, pd_s2;
	logic         oe_s1, oe_s2;
	logic         edge_hit;
	logic [W-1:0] pipe_word [LAT];
	logic         pipe_ovr  [LAT];
	logic [W-1:0] trk_word;
	logic [3:0]   trk_cnt;

	// Two-flop synchronisers; data rides at the same depth as its clock
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clk_s1  <= DAO_RST_BIT;
			clk_s2  <= DAO_RST_BIT;
			clk_s3  <= DAO_RST_BIT;
			data_s1 <= {W{DAO_RST_BIT}};
			data_s2 <= {W{DAO_RST_BIT}};
			ovr_s1  <= DAO_RST_BIT;
			ovr_s2  <= DAO_RST_BIT;
			pd_s1   <= DAO_RST_BIT;
			pd_s2   <= DAO_RST_BIT;
			oe_s1   <= DAO_RST_OE_N;
			oe_s2   <= DAO_RST_OE_N;
		end
		else
		begin
			clk_s1  <= sample_clock;
			clk_s2  <= clk_s1;
			clk_s3  <= clk_s2;
			data_s1 <= sample_in;
			data_s2 <= data_s1;
			ovr_s1  <= over_in;
			ovr_s2  <= ovr_s1;
			pd_s1   <= power_down;
			pd_s2   <= pd_s1;
			oe_s1   <= output_enable_n;
			oe_s2   <= oe_s1;
		end
	end

	// Rising edge of the sample clock starts a sample
	assign edge_hit = clk_s2 & ~clk_s3; // RULE1

	// Pipeline stalls in nap and sleep, keeps running while only tri-stated
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < LAT; i++)
			begin
				pipe_word[i] <= {W{DAO_RST_BIT}};
				pipe_ovr[i]  <= DAO_RST_BIT;
			end
		end
		else if (edge_hit && !pd_s2) // RULE6
		begin
			pipe_word[0] <= data_s2; // RULE1
			pipe_ovr[0]  <= ovr_s2;
			for (int i = 1; i < LAT; i++)
			begin
				pipe_word[i] <= pipe_word[i-1];
				pipe_ovr[i]  <= pipe_ovr[i-1];
			end
		end
	end

	// Output word after the pipeline; two's complement flips only the MSB
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ch.word <= {W{DAO_RST_BIT}};
			ch.ovr  <= DAO_RST_BIT;
		end
		else if (edge_hit && !pd_s2)
		begin
			ch.word <= {pipe_word[LAT-1][W-1] ^ twos_comp, pipe_word[LAT-1][W-2:0]}; // RULE15 RULE16 RULE9
			ch.ovr  <= pipe_ovr[LAT-1];
		end
	end

	// Mode, drive request and clock level for the output stage
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ch.state     <= DAO_ST_NORMAL;
			ch.drive     <= DAO_RST_BIT;
			ch.edge_seen <= DAO_RST_BIT;
			ch.clk_level <= DAO_RST_BIT;
		end
		else
		begin
			ch.state     <= dao_chan_state(pd_s2, oe_s2); // RULE5 RULE6 RULE7 RULE8
			ch.drive     <= !pd_s2 && !oe_s2;             // RULE5
			ch.edge_seen <= edge_hit;
			ch.clk_level <= clk_s2;
		end
	end

	// Checking aid: follows one sample through the pipeline
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			trk_cnt  <= 4'h0;
			trk_word <= {W{DAO_RST_BIT}};
		end
		else if (edge_hit && !pd_s2)
		begin
			if (trk_cnt == 4'h0)
			begin
				trk_word <= data_s2;
				trk_cnt  <= 4'h1;
			end
			else if (trk_cnt == 4'(LAT))
				trk_cnt <= 4'h0;
			else
				trk_cnt <= trk_cnt + 4'h1;
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_edge_takes_sample: assert property (edge_hit && !pd_s2 |=> pipe_word[0] == $past(data_s2)) // RULE1
		else $error("sample not taken on clock rise");
	a_latency_five: assert property (edge_hit && !pd_s2 && trk_cnt == 4'(LAT)
		|=> ch.word[W-2:0] == trk_word[W-2:0]) // RULE15
		else $error("sample did not appear after five edges");
	a_twos_msb_flip: assert property (edge_hit && !pd_s2 && trk_cnt == 4'(LAT)
		|=> ch.word[W-1] == (trk_word[W-1] ^ $past(twos_comp))) // RULE16
		else $error("format MSB wrong");
	a_normal_drives: assert property (!pd_s2 && !oe_s2 |=> ch.drive && ch.state == DAO_ST_NORMAL) // RULE5
		else $error("normal mode not driving");
	a_hiz_converts: assert property (!pd_s2 && oe_s2 && edge_hit
		|=> !ch.drive && pipe_word[0] == $past(data_s2)) // RULE6
		else $error("tri-state mode stopped converting");
	a_nap_frozen: assert property (pd_s2 && !oe_s2
		|=> ch.state == DAO_ST_NAP && !ch.drive && $stable(pipe_word[0])) // RULE7
		else $error("nap mode wrong");
	a_sleep_frozen: assert property (pd_s2 && oe_s2
		|=> ch.state == DAO_ST_SLEEP && !ch.drive && $stable(pipe_word[0])) // RULE8
		else $error("sleep mode wrong");

endmodule : dao_channel
`default_nettype wire

// >>> design/dao_top.sv
// Top of the dual converter output stage: bus swap, format select, flag, ready clock
`timescale 1ns/1ns
`default_nettype none
// ************************************************************************
// What this block does
// (RULE1) Each channel samples on its clock rise
// (RULE2) Swap high: A to bus A, B to B
// (RULE3) Swap low: buses exchanged between channels
// (RULE4) Interleave by tying swap and clocks, slow
// (RULE5) Up and enabled: convert and drive bus
// (RULE6) Up, disabled: convert, bus released
// (RULE7) Down, enabled: nap, bus released
// (RULE8) Down, disabled: sleep, bus released
// (RULE9) Twelve-bit words, top bit is MSB
// (RULE10) Receiver latches data on ready clock fall
// (RULE11) Ready clock follows the channel B clock
// (RULE12) Flag high on either channel's range excess
// (RULE13) Ground offset binary; third adds stabilizer
// (RULE14) Two thirds twos+stabilizer; supply twos only
// (RULE15) Output word five clock edges after sample
// (RULE16) Two's complement inverts the offset MSB
// ************************************************************************
module dao_top
	import dao_pkg::*;
#(
	parameter int WIDTH   = DAO_WIDTH,
	parameter int LATENCY = DAO_LATENCY
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Channel A pins
	input  wire logic             chan_a_sample_clock,
	input  wire logic [WIDTH-1:0] chan_a_sample,
	input  wire logic             chan_a_over,
	input  wire logic             chan_a_power_down,
	input  wire logic             chan_a_output_enable_n,
	// Channel B pins
	input  wire logic             chan_b_sample_clock,
	input  wire logic [WIDTH-1:0] chan_b_sample,
	input  wire logic             chan_b_over,
	input  wire logic             chan_b_power_down,
	input  wire logic             chan_b_output_enable_n,
	// Shared selectors
	input  wire logic             bus_swap_select,
	input  wire logic [1:0]       format_level,
	// Output bus A
	output logic      [WIDTH-1:0] bus_a_word,
	output logic                  bus_a_word_oe_n,
	// Output bus B
	output logic      [WIDTH-1:0] bus_b_word,
	output logic                  bus_b_word_oe_n,
	// Flags, ready clock and status
	output logic                  range_exceeded_flag,
	output logic                  data_ready_clock,
	output logic                  duty_stabilizer_on,
	output logic      [1:0]       chan_a_state,
	output logic      [1:0]       chan_b_state
);

	// ********************************************************************
	// Declarations
	// ********************************************************************
	logic       swap_s1;
	logic       swap_s2;
	logic [1:0] fmt_s1;
	logic [1:0] fmt_s2;
	logic       twos_comp;

	dao_chan_if #(.W(WIDTH)) a_if ();
	dao_chan_if #(.W(WIDTH)) b_if ();

	// ********************************************************************
	// Channel samplers
	// ********************************************************************
	dao_channel #(
		.W   (WIDTH),
		.LAT (LATENCY)
	) u_chan_a (
		.clk             (clk),
		.arst_n          (arst_n),
		.sample_clock    (chan_a_sample_clock),
		.sample_in       (chan_a_sample),
		.over_in         (chan_a_over),
		.power_down      (chan_a_power_down),
		.output_enable_n (chan_a_output_enable_n),
		.twos_comp       (twos_comp),
		.ch              (a_if.chan)
	);

	dao_channel #(
		.W   (WIDTH),
		.LAT (LATENCY)
	) u_chan_b (
		.clk             (clk),
		.arst_n          (arst_n),
		.sample_clock    (chan_b_sample_clock),
		.sample_in       (chan_b_sample),
		.over_in         (chan_b_over),
		.power_down      (chan_b_power_down),
		.output_enable_n (chan_b_output_enable_n),
		.twos_comp       (twos_comp),
		.ch              (b_if.chan)
	);

	// ********************************************************************
	// Shared selector synchronisers
	// ********************************************************************
	// Same depth as the sample clocks, so a swap tied to the clocks stays aligned
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			swap_s1 <= DAO_RST_BIT;
			swap_s2 <= DAO_RST_BIT;
			fmt_s1  <= DAO_LVL_GND;
			fmt_s2  <= DAO_LVL_GND;
		end
		else
		begin
			swap_s1 <= bus_swap_select; // RULE4
			swap_s2 <= swap_s1;
			fmt_s1  <= format_level;
			fmt_s2  <= fmt_s1;
		end
	end

	// Format and stabilizer decode; a format change mid-stream hits the next word
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			twos_comp          <= DAO_RST_BIT;
			duty_stabilizer_on <= DAO_RST_BIT;
		end
		else
		begin
			twos_comp          <= dao_twos_sel(fmt_s2); // RULE13 RULE14
			duty_stabilizer_on <= dao_dcs_sel(fmt_s2);  // RULE13 RULE14
		end
	end

	// ********************************************************************
	// Output routing
	// ********************************************************************
	// Bus A: a released bus shows zeros so stale data never leaks
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_a_word      <= {WIDTH{DAO_RST_BIT}};
			bus_a_word_oe_n <= DAO_RST_OE_N;
		end
		else if (swap_s2)
		begin
			bus_a_word      <= a_if.drive ? a_if.word : {WIDTH{DAO_RST_BIT}}; // RULE2
			bus_a_word_oe_n <= !a_if.drive;                                 // RULE2 RULE6
		end
		else
		begin
			bus_a_word      <= b_if.drive ? b_if.word : {WIDTH{DAO_RST_BIT}}; // RULE3
			bus_a_word_oe_n <= !b_if.drive;                                 // RULE3 RULE7
		end
	end

	// Bus B: mirror of bus A
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_b_word      <= {WIDTH{DAO_RST_BIT}};
			bus_b_word_oe_n <= DAO_RST_OE_N;
		end
		else if (swap_s2)
		begin
			bus_b_word      <= b_if.drive ? b_if.word : {WIDTH{DAO_RST_BIT}}; // RULE2
			bus_b_word_oe_n <= !b_if.drive;                                 // RULE2 RULE8
		end
		else
		begin
			bus_b_word      <= a_if.drive ? a_if.word : {WIDTH{DAO_RST_BIT}}; // RULE3
			bus_b_word_oe_n <= !a_if.drive;                                 // RULE3 RULE5
		end
	end

	// ********************************************************************
	// Flag, ready clock and status
	// ********************************************************************
	// Combined range flag; a sleeping channel holds its last flag
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			range_exceeded_flag <= DAO_RST_BIT;
		else
			range_exceeded_flag <= a_if.ovr || b_if.ovr; // RULE12
	end

	// Ready clock rises with the new words; its fall is half a period later
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			data_ready_clock <= DAO_RST_BIT;
		else
			data_ready_clock <= b_if.clk_level; // RULE11 RULE10
	end

	// Mode status of both channels
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			chan_a_state <= DAO_ST_NORMAL;
			chan_b_state <= DAO_ST_NORMAL;
		end
		else
		begin
			chan_a_state <= a_if.state;
			chan_b_state <= b_if.state;
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_swap_high_a: assert property (swap_s2 && a_if.drive
		|=> bus_a_word == $past(a_if.word) && !bus_a_word_oe_n) // RULE2
		else $error("bus A not carrying channel A");
	a_swap_high_b: assert property (swap_s2 && b_if.drive
		|=> bus_b_word == $past(b_if.word) && !bus_b_word_oe_n) // RULE2
		else $error("bus B not carrying channel B");
	a_swap_low_a: assert property (!swap_s2 && b_if.drive
		|=> bus_a_word == $past(b_if.word) && !bus_a_word_oe_n) // RULE3
		else $error("bus A not carrying channel B");
	a_swap_low_b: assert property (!swap_s2 && a_if.drive
		|=> bus_b_word == $past(a_if.word) && !bus_b_word_oe_n) // RULE3
		else $error("bus B not carrying channel A");
	a_idle_bus_hiz: assert property (swap_s2 && !a_if.drive
		|=> bus_a_word_oe_n && bus_a_word == {WIDTH{DAO_RST_BIT}}) // RULE6
		else $error("released bus still driven");
	a_flag_either: assert property ((a_if.ovr || b_if.ovr) |=> range_exceeded_flag) // RULE12
		else $error("range flag missed");
	a_flag_clear: assert property (!a_if.ovr && !b_if.ovr |=> !range_exceeded_flag) // RULE12
		else $error("range flag without cause");
	a_fmt_ground: assert property (fmt_s2 == DAO_LVL_GND
		|=> !twos_comp && !duty_stabilizer_on) // RULE13
		else $error("ground level decode wrong");
	a_fmt_third: assert property (fmt_s2 == DAO_LVL_THIRD
		|=> !twos_comp && duty_stabilizer_on) // RULE13
		else $error("third level decode wrong");
	a_fmt_two_thirds: assert property (fmt_s2 == DAO_LVL_TWO_THIRDS
		|=> twos_comp && duty_stabilizer_on) // RULE14
		else $error("two thirds level decode wrong");
	a_fmt_supply: assert property (fmt_s2 == DAO_LVL_SUPPLY
		|=> twos_comp && !duty_stabilizer_on) // RULE14
		else $error("supply level decode wrong");
	a_ready_from_b: assert property ($rose(data_ready_clock) |-> $past(b_if.edge_seen)) // RULE11
		else $error("ready clock rose without channel B edge");
	a_ready_follows: assert property (b_if.edge_seen |=> data_ready_clock) // RULE11
		else $error("ready clock missed channel B edge");

	c_swap_flip:  cover property ($fell(swap_s2) ##[1:20] $rose(swap_s2));
	c_nap_a:      cover property (a_if.state == DAO_ST_NAP);
	c_flag_rise:  cover property ($rose(range_exceeded_flag));
	c_twos_ready: cover property (twos_comp && $rose(data_ready_clock));

endmodule : dao_top
`default_nettype wire

// >>> tb/dao_capture.sv
// Capture model: latches both output buses on the falling edge of the ready clock
`timescale 1ns/1ns
`default_nettype none
module dao_capture
	import dao_pkg::*;
(
	// Ready clock from the block
	input  wire logic                 data_ready_clock,
	// Output buses and flag
	input  wire logic [DAO_WIDTH-1:0] bus_a_word,
	input  wire logic                 bus_a_word_oe_n,
	input  wire logic [DAO_WIDTH-1:0] bus_b_word,
	input  wire logic                 bus_b_word_oe_n,
	input  wire logic                 range_exceeded_flag,
	// Captured values
	output logic      [DAO_WIDTH-1:0] cap_a,
	output logic      [DAO_WIDTH-1:0] cap_b,
	output logic                      cap_flag,
	output int                        cap_count
);
	// Count of falling edges seen
	initial cap_count = 0;

	// A released bus has no pull, so the wire shows the inverse of its last level
	always @(negedge data_ready_clock)
	begin
		cap_a     <= bus_a_word_oe_n ? ~cap_a : bus_a_word;
		cap_b     <= bus_b_word_oe_n ? ~cap_b : bus_b_word;
		cap_flag  <= range_exceeded_flag;
		cap_count <= cap_count + 1;
	end
endmodule : dao_capture
`default_nettype wire

// >>> tb/test_dao_top.sv
// Self-checking bench of the dual converter output stage
`timescale 1ns/1ns
`default_nettype none
module test_dao_top;
	import dao_pkg::*;

	// ********************************************************************
	// Signals
	// ********************************************************************
	logic                 clk, arst_n, bus_swap_select;
	logic                 chan_a_sample_clock, chan_b_sample_clock;
	logic                 chan_a_over, chan_b_over;
	logic                 chan_a_power_down, chan_b_power_down;
	logic                 chan_a_output_enable_n, chan_b_output_enable_n;
	logic [DAO_WIDTH-1:0] chan_a_sample, chan_b_sample, bus_a_word, bus_b_word;
	logic [DAO_WIDTH-1:0] cap_a, cap_b;
	logic [1:0]           format_level, chan_a_state, chan_b_state;
	logic                 bus_a_word_oe_n, bus_b_word_oe_n, range_exceeded_flag;
	logic                 data_ready_clock, duty_stabilizer_on, cap_flag;
	int                   cap_count, bad_count, samples_checked, seq, c0;
	logic [12:0]          qa[$], qb[$];            // {over, sample} per taken rise
	logic [12:0]          cur_a, cur_b, prev_a, prev_b;
	bit                   va, vb, pva, pvb, chk;
	bit                   tie;                     // Swap pin follows both sample clocks

	// ********************************************************************
	// Block and capture model
	// ********************************************************************
	dao_top u_dut (.clk(clk), .arst_n(arst_n),
		.chan_a_sample_clock(chan_a_sample_clock), .chan_a_sample(chan_a_sample),
		.chan_a_over(chan_a_over), .chan_a_power_down(chan_a_power_down),
		.chan_a_output_enable_n(chan_a_output_enable_n),
		.chan_b_sample_clock(chan_b_sample_clock), .chan_b_sample(chan_b_sample),
		.chan_b_over(chan_b_over), .chan_b_power_down(chan_b_power_down),
		.chan_b_output_enable_n(chan_b_output_enable_n),
		.bus_swap_select(bus_swap_select), .format_level(format_level),
		.bus_a_word(bus_a_word), .bus_a_word_oe_n(bus_a_word_oe_n),
		.bus_b_word(bus_b_word), .bus_b_word_oe_n(bus_b_word_oe_n),
		.range_exceeded_flag(range_exceeded_flag), .data_ready_clock(data_ready_clock),
		.duty_stabilizer_on(duty_stabilizer_on), .chan_a_state(chan_a_state),
		.chan_b_state(chan_b_state));

	dao_capture u_capture (.data_ready_clock(data_ready_clock), .bus_a_word(bus_a_word),
		.bus_a_word_oe_n(bus_a_word_oe_n), .bus_b_word(bus_b_word),
		.bus_b_word_oe_n(bus_b_word_oe_n), .range_exceeded_flag(range_exceeded_flag),
		.cap_a(cap_a), .cap_b(cap_b), .cap_flag(cap_flag), .cap_count(cap_count));

	// ********************************************************************
	// Shared tasks
	// ********************************************************************
	// Compare and report
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Verdict and end of run
	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	// One 80 ns sample period; data held four cycles either side of the rise
	task automatic do_period(input logic [11:0] sa, input logic [11:0] sb, input logic oa,
		input logic ob, input bit run_a);
		logic [11:0] msb;
		logic        da;
		logic        db;
		logic        sw;
		@(posedge clk);
		chan_a_sample_clock <= 1'b0;
		chan_b_sample_clock <= 1'b0;
		if (tie)
			bus_swap_select <= 1'b0;
		chan_a_sample       <= sa;
		chan_b_sample       <= sb;
		chan_a_over         <= oa;
		chan_b_over         <= ob;
		repeat (4) @(posedge clk);
		chan_a_sample_clock <= run_a;
		chan_b_sample_clock <= 1'b1;
		if (tie)
			bus_swap_select <= 1'b1;
		pva    = va;
		pvb    = vb;
		prev_a = cur_a;
		prev_b = cur_b;
		// Frozen channels take no sample, so their word stands
		if (run_a && !chan_a_power_down)
		begin
			qa.push_back({oa, sa});
			va = qa.size() > 5;
			if (va)
				cur_a = qa[qa.size() - 6];
		end
		if (!chan_b_power_down)
		begin
			qb.push_back({ob, sb});
			vb = qb.size() > 5;
			if (vb)
				cur_b = qb[qb.size() - 6];
		end
		repeat (3) @(posedge clk);
		if (chk)
		begin
			da  = !chan_a_power_down && !chan_a_output_enable_n;
			db  = !chan_b_power_down && !chan_b_output_enable_n;
			// A tied swap pin is low at every ready clock fall, so buses read as swapped
			sw  = bus_swap_select && !tie;
			msb = {format_level[1], 11'h000};
			if (pva && pvb)
				check("range_exceeded_flag", 16'(prev_a[12] | prev_b[12]), 16'(cap_flag));
			if (sw && pva && da)
				check("bus_a_word", 16'(prev_a[11:0] ^ msb), 16'(cap_a));
			if (sw && pvb && db)
				check("bus_b_word", 16'(prev_b[11:0] ^ msb), 16'(cap_b));
			if (!sw && pvb && db)
				check("bus_a_word", 16'(prev_b[11:0] ^ msb), 16'(cap_a));
			if (!sw && pva && da)
				check("bus_b_word", 16'(prev_a[11:0] ^ msb), 16'(cap_b));
		end
	endtask : do_period

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	// Stream of samples under one swap and format; first capture skipped while settling
	task automatic t_stream(input logic sw, input logic [1:0] fmt, input int n, input bit run_a);
		@(posedge clk);
		bus_swap_select <= sw;
		format_level    <= fmt;
		chk = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			seq = seq + 1;
			do_period(12'(seq * 12'h1a7), 12'(seq * 12'h2c9), seq[2], seq[3] & seq[0], run_a);
			chk = 1'b1;
		end
		check("duty_stabilizer_on", 16'(fmt == 2'h1 || fmt == 2'h2), 16'(duty_stabilizer_on));
	endtask : t_stream

	// Both channels to one mode, then B back to normal so the stream checks the bus words of channel B again
	task automatic t_modes(input logic [1:0] m);
		@(posedge clk);
		{chan_a_power_down, chan_a_output_enable_n} <= m;
		{chan_b_power_down, chan_b_output_enable_n} <= m;
		repeat (6) @(posedge clk);
		check("chan_a_state", 16'(m), 16'(chan_a_state));
		check("chan_b_state", 16'(m), 16'(chan_b_state));
		check("bus_a_word_oe_n", 16'(m != 2'h0), 16'(bus_a_word_oe_n));
		check("bus_b_word_oe_n", 16'(m != 2'h0), 16'(bus_b_word_oe_n));
		if (m != 2'h0)
			check("bus_a_word", 16'h0000, 16'(bus_a_word));
		{chan_b_power_down, chan_b_output_enable_n} <= 2'h0;
		repeat (4) @(posedge clk);
		t_stream(1'b1, 2'h0, 4, 1'b1);
	endtask : t_modes

	// Swap pin tied to both clocks; low phase at capture puts B on bus A
	task automatic t_interleave(input int n);
		tie = 1'b1;
		t_stream(1'b0, 2'h0, n, 1'b1);
		tie = 1'b0;
	endtask : t_interleave

	// ********************************************************************
	// Clock, watchdog and main sequence
	// ********************************************************************
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// About 710 cycles are expected; the limit leaves wide margin
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		wrap_up();
	end

	// Reset, then the scenarios in turn
	initial
	begin
		{arst_n, chan_a_sample_clock, chan_b_sample_clock, chan_a_over, chan_b_over} = '0;
		{chan_a_power_down, chan_b_power_down} = '0;
		{chan_a_output_enable_n, chan_b_output_enable_n} = '0;
		{chan_a_sample, chan_b_sample, format_level} = '0;
		bus_swap_select = 1'b1;
		bad_count       = 0;
		samples_checked = 0;
		seq             = 0;
		repeat (3) @(posedge clk);
		check("bus_a_word_oe_n", 16'h0001, 16'(bus_a_word_oe_n));
		arst_n <= 1'b1;
		t_stream(1'b1, 2'h0, 10, 1'b1);
		t_stream(1'b0, 2'h1, 8, 1'b1);
		t_stream(1'b1, 2'h2, 8, 1'b1);
		t_stream(1'b0, 2'h3, 8, 1'b1);
		for (int m = 0; m < 4; m++)
			t_modes(2'(m));
		t_modes(2'h0);
		t_stream(1'b1, 2'h0, 8, 1'b1);
		c0 = cap_count;
		t_stream(1'b1, 2'h0, 4, 1'b0);
		check("ready_clock_falls", 16'h0004, 16'(cap_count - c0));
		t_interleave(6);
		t_stream(1'b0, 2'h2, 8, 1'b1);
		wrap_up();
	end
endmodule : test_dao_top
`default_nettype wire
